// >>> verilog/crs_pkg.sv
// constants and carrier types for the core special register set
package crs_pkg;
  localparam int unsigned CRS_NUM_GPR   = 13;
  localparam logic [3:0]  CRS_IDX_SP    = 4'hD;
  localparam logic [3:0]  CRS_IDX_LINK  = 4'hE;
  localparam logic [3:0]  CRS_IDX_PC    = 4'hF;
  // vector table addresses used at reset
  localparam logic [31:0] CRS_VEC_SP_ADDR = 32'h00000000;
  localparam logic [31:0] CRS_VEC_PC_ADDR = 32'h00000004;
  // field positions
  localparam int unsigned CRS_FLAG_N_POS  = 31;
  localparam int unsigned CRS_FLAG_Z_POS  = 30;
  localparam int unsigned CRS_FLAG_C_POS  = 29;
  localparam int unsigned CRS_FLAG_V_POS  = 28;
  localparam int unsigned CRS_ISA_POS     = 24;
  localparam int unsigned CRS_EXC_MSB     = 5;
  localparam int unsigned CRS_CTRL_SP_POS = 1;
  localparam int unsigned CRS_MASK_POS    = 0;
  // field masks within the 32-bit status word
  localparam logic [31:0] CRS_FLAG_MASK = 32'hF0000000;
  localparam logic [31:0] CRS_EXC_MASK  = 32'h0000003F;
  localparam logic [31:0] CRS_EXEC_MASK = 32'h01000000;
  // reset values
  localparam logic [5:0]  CRS_EXC_RESET  = 6'h00;
  localparam logic        CRS_MASK_RESET = 1'b0;
  localparam logic        CRS_SPSEL_RESET = 1'b0;
  // exception numbers
  localparam logic [5:0]  CRS_EXC_THREAD   = 6'h00;
  localparam logic [5:0]  CRS_EXC_NMI      = 6'h02;
  localparam logic [5:0]  CRS_EXC_FATAL    = 6'h03;
  localparam logic [5:0]  CRS_EXC_SVC      = 6'h0B;
  localparam logic [5:0]  CRS_EXC_PENDSVC  = 6'h0E;
  localparam logic [5:0]  CRS_EXC_SYSTEM_TICK_EXC  = 6'h0F;
  localparam logic [5:0]  CRS_EXC_IRQ_LO   = 6'h10;
  localparam logic [5:0]  CRS_EXC_IRQ_HI   = 6'h2F;

  // special register selectors for move instructions
  typedef enum logic [3:0] {
    CRS_SR_FLAG      = 4'h0,
    CRS_SR_FLAG_EXC  = 4'h1,
    CRS_SR_FLAG_EXEC = 4'h2,
    CRS_SR_ALL       = 4'h3,
    CRS_SR_EXC       = 4'h5,
    CRS_SR_EXC_EXEC  = 4'h6,
    CRS_SR_EXEC      = 4'h7,
    CRS_SR_MSP       = 4'h8,
    CRS_SR_PSP       = 4'h9,
    CRS_SR_MASK      = 4'hA,
    CRS_SR_CONTROL   = 4'hB
  } crs_sr_sel_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } crs_gpr_wr_t;

  typedef struct packed {
    logic        we;
    crs_sr_sel_t sel;
    logic [31:0] data;
  } crs_sr_wr_t;

  typedef struct packed {
    logic       we;
    logic [3:0] nzcv;
  } crs_flag_wr_t;

  // exception entry / return event
  typedef struct packed {
    logic        entry;
    logic        ret;
    logic [5:0]  exc_num;
    logic [31:0] vector;
    logic [31:0] stacked_psr;
    logic        ret_spsel;
  } crs_exc_evt_t;
endpackage

// >>> verilog/crs_core_regs.sv
// core special register set: gprs, banked sp, link, pc, status word, mask, control
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) thirteen 32-bit data registers, reset undefined
// (RULE2) r13 picks main or process stack
// (RULE3) reset loads main stack from address 0
// (RULE4) reset loads pc from 4, bit0 isa
// (RULE5) r14 holds return link, reset unspecified
// (RULE6) three status parts, combinable move views
// (RULE7) writes never change active exception field
// (RULE8) exec-state reads zero, writes ignored
// (RULE9) flags at bits 31..28, rest reserved
// (RULE10) exception number in bits 5:0
// (RULE11) isa flag at bit 24 only
// (RULE12) isa flag cleared by branch, return, vector
// (RULE13) executing with isa clear raises fatal fault
// (RULE14) exception entry stacks execution-state bits
// (RULE15) interrupt abandons multi-register load/store
// (RULE16) restart abandoned multi transfer from beginning
// (RULE17) mask bit0 blocks configurable priority exceptions
// (RULE18) mask set by moves or state-change instruction
// (RULE19) handler mode always uses main stack
// (RULE20) handler mode: stack select reads zero
// (RULE21) reserved bits read zero, ignore writes
module crs_core_regs
  import crs_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // reset vector fetch results, valid while i_vec_valid
  input  wire logic         i_vec_valid,
  input  wire logic [31:0]  i_vec_sp,
  input  wire logic [31:0]  i_vec_pc,
  input  wire crs_gpr_wr_t  i_gpr_wr,
  input  wire logic [3:0]   i_gpr_rd_idx,
  input  wire logic         i_pc_we,
  input  wire logic [31:0]  i_pc_data,
  input  wire logic         i_exchange,
  input  wire crs_flag_wr_t i_flag_wr,
  input  wire crs_sr_wr_t   i_sr_wr,
  input  wire crs_sr_sel_t  i_sr_rd_sel,
  input  wire logic         i_cps_we,
  input  wire logic         i_cps_disable,
  input  wire crs_exc_evt_t i_exc,
  input  wire logic         i_exec_req,
  input  wire logic         i_multi_start,
  input  wire logic [31:0]  i_multi_pc,
  input  wire logic         i_multi_done,
  input  wire logic         i_irq_take,
  input  wire logic         i_cfg_prio_req,
  output logic              o_ready,
  output logic [31:0]       o_gpr_rd,
  output logic [31:0]       o_sp,
  output logic [31:0]       o_pc,
  output logic [31:0]       o_sr_rd,
  output logic [31:0]       o_stack_psr,
  output logic              o_handler,
  output logic              o_fatal_fault,
  output logic              o_multi_abandon,
  output logic              o_cfg_prio_block
);

  typedef enum logic [1:0] {
    ST_FETCH_VEC,
    ST_RUN
  } crs_state_t;

  crs_state_t  state_q;
  logic [31:0] gpr_q [CRS_NUM_GPR];
  logic [31:0] main_sp_q;
  logic [31:0] proc_sp_q;
  logic [31:0] link_q;
  logic [31:0] pc_q;
  logic [3:0]  nzcv_q;
  logic [5:0]  exc_q;
  logic        isa_q;
  logic        mask_q;
  logic        spsel_q;
  logic        multi_act_q;
  logic [31:0] multi_pc_q;
  logic        running;
  logic        handler;
  logic        use_psp;
  logic [31:0] psr_full;

  // full status word, execution part included for stacking
  // (RULE11) isa flag at bit 24
  function automatic logic [31:0] build_psr(input logic [3:0] f, input logic [5:0] e,
                                            input logic t);
    logic [31:0] w;
    w = 32'h00000000;
    w[CRS_FLAG_N_POS:CRS_FLAG_V_POS] = f;
    w[CRS_EXC_MSB:0] = e;
    w[CRS_ISA_POS] = t;
    return w;
  endfunction

  function automatic logic sel_has_flags(input crs_sr_sel_t s);
    return (s == CRS_SR_FLAG) || (s == CRS_SR_FLAG_EXC) ||
           (s == CRS_SR_FLAG_EXEC) || (s == CRS_SR_ALL);
  endfunction

  function automatic logic sel_has_exc(input crs_sr_sel_t s);
    return (s == CRS_SR_FLAG_EXC) || (s == CRS_SR_ALL) ||
           (s == CRS_SR_EXC) || (s == CRS_SR_EXC_EXEC);
  endfunction

  // exec part never enters a read mask, so those views see zero there
  function automatic logic [31:0] view_mask(input crs_sr_sel_t s);
    logic [31:0] m;
    m = 32'h00000000;
    if (sel_has_flags(s)) begin
      m = m | CRS_FLAG_MASK;
    end
    if (sel_has_exc(s)) begin
      m = m | CRS_EXC_MASK;
    end
    return m;
  endfunction

  assign running  = (state_q == ST_RUN);
  assign handler  = (exc_q != CRS_EXC_THREAD);
  // (RULE19) handler forces main stack
  assign use_psp  = spsel_q && !handler;
  assign psr_full = build_psr(nzcv_q, exc_q, isa_q);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_FETCH_VEC;
    end else if (state_q == ST_FETCH_VEC && i_vec_valid) begin
      state_q <= ST_RUN;
    end
  end

  // (RULE1) data registers, no reset on purpose
  always_ff @(posedge i_clk) begin
    if (running && i_gpr_wr.we && i_gpr_wr.idx < CRS_IDX_SP) begin
      gpr_q[i_gpr_wr.idx] <= i_gpr_wr.data;
    end
  end

  // (RULE3) main stack loaded from word zero
  always_ff @(posedge i_clk) begin
    if (state_q == ST_FETCH_VEC) begin
      if (i_vec_valid) begin
        main_sp_q <= i_vec_sp;
      end
    end else if (i_sr_wr.we && i_sr_wr.sel == CRS_SR_MSP) begin
      main_sp_q <= i_sr_wr.data;
    // (RULE2) r13 writes go to selected stack
    end else if (i_gpr_wr.we && i_gpr_wr.idx == CRS_IDX_SP && !use_psp) begin
      main_sp_q <= i_gpr_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (running && i_sr_wr.we && i_sr_wr.sel == CRS_SR_PSP) begin
      proc_sp_q <= i_sr_wr.data;
    end else if (running && i_gpr_wr.we && i_gpr_wr.idx == CRS_IDX_SP && use_psp) begin
      proc_sp_q <= i_gpr_wr.data;
    end
  end

  // (RULE5) return link, reset left unspecified
  always_ff @(posedge i_clk) begin
    if (running && i_gpr_wr.we && i_gpr_wr.idx == CRS_IDX_LINK) begin
      link_q <= i_gpr_wr.data;
    end
  end

  // (RULE4) pc from vector word at four
  always_ff @(posedge i_clk) begin
    if (state_q == ST_FETCH_VEC) begin
      if (i_vec_valid) begin
        pc_q <= {i_vec_pc[31:1], 1'b0};
      end
    end else if (i_exc.entry) begin
      pc_q <= {i_exc.vector[31:1], 1'b0};
    // (RULE16) resume multi transfer from start
    end else if (i_exc.ret && multi_act_q) begin
      pc_q <= multi_pc_q;
    end else if (i_pc_we) begin
      pc_q <= {i_pc_data[31:1], 1'b0};
    end
  end

  // (RULE12) isa flag load and clear paths
  always_ff @(posedge i_clk) begin
    if (state_q == ST_FETCH_VEC) begin
      if (i_vec_valid) begin
        isa_q <= i_vec_pc[0];
      end
    end else if (i_exc.entry) begin
      isa_q <= i_exc.vector[0];
    end else if (i_exc.ret) begin
      isa_q <= i_exc.stacked_psr[CRS_ISA_POS];
    end else if (i_pc_we && i_exchange) begin
      isa_q <= i_pc_data[0];
    end
  end

  // (RULE9) flags from alu or move writes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      nzcv_q <= 4'h0;
    end else if (i_exc.ret) begin
      nzcv_q <= i_exc.stacked_psr[CRS_FLAG_N_POS:CRS_FLAG_V_POS];
    end else if (i_sr_wr.we && sel_has_flags(i_sr_wr.sel)) begin
      nzcv_q <= i_sr_wr.data[CRS_FLAG_N_POS:CRS_FLAG_V_POS];
    end else if (i_flag_wr.we) begin
      nzcv_q <= i_flag_wr.nzcv;
    end
  end

  // (RULE7) only reset, entry and return move the exception field
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      exc_q <= CRS_EXC_RESET;
    end else if (i_exc.entry) begin
      // (RULE10) six-bit exception number
      exc_q <= i_exc.exc_num;
    end else if (i_exc.ret) begin
      exc_q <= i_exc.stacked_psr[CRS_EXC_MSB:0];
    end
  end

  // (RULE18) mask via moves or state-change instr
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mask_q <= CRS_MASK_RESET;
    end else if (i_cps_we) begin
      mask_q <= i_cps_disable;
    end else if (i_sr_wr.we && i_sr_wr.sel == CRS_SR_MASK) begin
      mask_q <= i_sr_wr.data[CRS_MASK_POS];
    end
  end

  // (RULE20) handler ignores writes; entry/return update it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      spsel_q <= CRS_SPSEL_RESET;
    end else if (i_exc.entry) begin
      spsel_q <= 1'b0;
    end else if (i_exc.ret) begin
      spsel_q <= i_exc.ret_spsel;
    end else if (i_sr_wr.we && i_sr_wr.sel == CRS_SR_CONTROL && !handler) begin
      spsel_q <= i_sr_wr.data[CRS_CTRL_SP_POS];
    end
  end

  // (RULE15) remember multi transfer start for abandon
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      multi_act_q <= 1'b0;
      multi_pc_q  <= 32'h00000000;
    end else if (i_multi_start) begin
      multi_act_q <= 1'b1;
      multi_pc_q  <= i_multi_pc;
    end else if (i_multi_done || i_exc.ret) begin
      multi_act_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_multi_abandon <= 1'b0;
    end else begin
      o_multi_abandon <= multi_act_q && i_irq_take && !i_multi_done;
    end
  end

  // (RULE13) fetch with isa clear is fatal
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fatal_fault <= 1'b0;
    end else begin
      o_fatal_fault <= running && i_exec_req && !isa_q;
    end
  end

  // (RULE17) mask blocks configurable-priority requests
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cfg_prio_block <= 1'b0;
    end else begin
      o_cfg_prio_block <= i_cfg_prio_req && mask_q;
    end
  end

  // (RULE14) stacked word carries execution bits
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_stack_psr <= 32'h00000000;
    end else if (i_exc.entry) begin
      o_stack_psr <= psr_full;
    end
  end

  // (RULE6) move-read views; (RULE8) exec bits read zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sr_rd <= 32'h00000000;
    end else begin
      case (i_sr_rd_sel)
        CRS_SR_FLAG, CRS_SR_FLAG_EXC, CRS_SR_FLAG_EXEC, CRS_SR_ALL,
        CRS_SR_EXC, CRS_SR_EXC_EXEC, CRS_SR_EXEC: begin
          o_sr_rd <= psr_full & view_mask(i_sr_rd_sel);
        end
        CRS_SR_MSP:                    o_sr_rd <= main_sp_q;
        CRS_SR_PSP:                    o_sr_rd <= proc_sp_q;
        // (RULE21) reserved bits read zero
        CRS_SR_MASK:    o_sr_rd <= {31'h0, mask_q};
        CRS_SR_CONTROL: o_sr_rd <= {30'h0, use_psp, 1'b0};
        default:        o_sr_rd <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_gpr_rd <= 32'h00000000;
    end else if (i_gpr_rd_idx < CRS_IDX_SP) begin
      o_gpr_rd <= gpr_q[i_gpr_rd_idx];
    end else if (i_gpr_rd_idx == CRS_IDX_SP) begin
      o_gpr_rd <= use_psp ? proc_sp_q : main_sp_q;
    end else if (i_gpr_rd_idx == CRS_IDX_LINK) begin
      o_gpr_rd <= link_q;
    end else begin
      o_gpr_rd <= pc_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ready   <= 1'b0;
      o_sp      <= 32'h00000000;
      o_pc      <= 32'h00000000;
      o_handler <= 1'b0;
    end else begin
      o_ready   <= running;
      o_sp      <= use_psp ? proc_sp_q : main_sp_q;
      o_pc      <= pc_q;
      o_handler <= handler;
    end
  end

endmodule

// >>> sim/crs_core_regs_sva.sv
// assertion checker for the core special register set
`timescale 1ns/1ps
module crs_core_regs_sva
  import crs_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_vec_valid,
  input wire crs_sr_sel_t i_sr_rd_sel,
  input wire logic        i_exec_req,
  input wire logic        i_multi_start,
  input wire logic        i_irq_take,
  input wire logic        i_cfg_prio_req,
  input wire logic        o_ready,
  input wire logic [31:0] o_sr_rd,
  input wire logic        o_handler,
  input wire logic        o_fatal_fault,
  input wire logic        o_multi_abandon,
  input wire logic        o_cfg_prio_block
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_multi_irq;
    i_multi_start ##1 i_irq_take;
  endsequence
  AST_ABANDON: assert property (s_multi_irq |=> o_multi_abandon)
    else $error("abandon missing");
  AST_ABANDON_CAUSE: assert property (o_multi_abandon |-> $past(i_irq_take))
    else $error("abandon without interrupt");
  AST_READY: assert property ($rose(o_ready) |-> $past(i_vec_valid, 2))
    else $error("ready without vectors");
  AST_EXEC_ZERO: assert property ($past(i_sr_rd_sel) < CRS_SR_MSP |-> o_sr_rd[24] == 1'b0)
    else $error("exec bit visible");
  AST_FLAG_RSV: assert property ($past(i_sr_rd_sel) == CRS_SR_FLAG |-> o_sr_rd[27:0] == 28'h0)
    else $error("flag reserved bits set");
  AST_EXC_RSV: assert property ($past(i_sr_rd_sel) == CRS_SR_EXC |-> o_sr_rd[31:6] == 26'h0)
    else $error("exception reserved bits set");
  AST_MASK_RSV: assert property ($past(i_sr_rd_sel) == CRS_SR_MASK |-> o_sr_rd[31:1] == 31'h0)
    else $error("mask reserved bits set");
  AST_CTRL_HANDLER: assert property ($past(i_sr_rd_sel) == CRS_SR_CONTROL && o_handler
    && $past(o_handler) |-> o_sr_rd[1] == 1'b0) else $error("stack select visible in handler");
  AST_FATAL_CAUSE: assert property (o_fatal_fault |-> $past(i_exec_req))
    else $error("fault without execute attempt");
  AST_BLOCK_CAUSE: assert property (o_cfg_prio_block |-> $past(i_cfg_prio_req))
    else $error("block without request");
endmodule

// >>> sim/tb_crs_core_regs.sv
// self-checking testbench for the core special register set
`timescale 1ns/1ps
module tb_crs_core_regs;
  import crs_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_reset = 1'b1;
  logic         i_vec_valid = 1'b0;
  logic [31:0]  i_vec_sp = 32'h0;
  logic [31:0]  i_vec_pc = 32'h0;
  crs_gpr_wr_t  i_gpr_wr = '0;
  logic [3:0]   i_gpr_rd_idx = 4'h0;
  logic         i_pc_we = 1'b0;
  logic [31:0]  i_pc_data = 32'h0;
  logic         i_exchange = 1'b0;
  crs_flag_wr_t i_flag_wr = '0;
  crs_sr_wr_t   i_sr_wr = '0;
  crs_sr_sel_t  i_sr_rd_sel = CRS_SR_FLAG;
  logic         i_cps_we = 1'b0;
  logic         i_cps_disable = 1'b0;
  crs_exc_evt_t i_exc = '0;
  logic         i_exec_req = 1'b0;
  logic         i_multi_start = 1'b0;
  logic [31:0]  i_multi_pc = 32'h0;
  logic         i_multi_done = 1'b0;
  logic         i_irq_take = 1'b0;
  logic         i_cfg_prio_req = 1'b0;
  logic         o_ready, o_handler, o_fatal_fault, o_multi_abandon, o_cfg_prio_block;
  logic [31:0]  o_gpr_rd, o_sp, o_pc, o_sr_rd, o_stack_psr;
  int           err_count = 0;
  int           compares = 0;
  logic [15:0]  lfsr = 16'h5974;
  logic [3:0]   flags = 4'h0;
  logic [31:0]  d, main_stack_pointer, process_stack_pointer, v;
  crs_sr_sel_t  vw[7] = '{CRS_SR_FLAG, CRS_SR_FLAG_EXC, CRS_SR_FLAG_EXEC, CRS_SR_ALL,
                          CRS_SR_EXC, CRS_SR_EXC_EXEC, CRS_SR_EXEC};
  logic [5:0]   ec[7] = '{CRS_EXC_NMI, CRS_EXC_FATAL, CRS_EXC_SVC, CRS_EXC_PENDSVC,
                          CRS_EXC_SYSTEM_TICK_EXC, CRS_EXC_IRQ_LO, CRS_EXC_IRQ_HI};

  crs_core_regs u_dut (.i_clk, .i_reset, .i_vec_valid, .i_vec_sp, .i_vec_pc, .i_gpr_wr,
    .i_gpr_rd_idx, .i_pc_we, .i_pc_data, .i_exchange, .i_flag_wr, .i_sr_wr, .i_sr_rd_sel,
    .i_cps_we, .i_cps_disable, .i_exc, .i_exec_req, .i_multi_start, .i_multi_pc,
    .i_multi_done, .i_irq_take, .i_cfg_prio_req, .o_ready, .o_gpr_rd, .o_sp, .o_pc,
    .o_sr_rd, .o_stack_psr, .o_handler, .o_fatal_fault, .o_multi_abandon, .o_cfg_prio_block);

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    for (int k = 0; k < 32; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
    return {lfsr, lfsr ^ 16'hA5C3};
  endfunction

  // view read value: exec part always hidden
  function automatic logic [31:0] vexp(crs_sr_sel_t s, logic [3:0] f, logic [5:0] e);
    vexp = 32'h0;
    if (s inside {CRS_SR_FLAG, CRS_SR_FLAG_EXC, CRS_SR_FLAG_EXEC, CRS_SR_ALL}) vexp[31:28] = f;
    if (s inside {CRS_SR_FLAG_EXC, CRS_SR_ALL, CRS_SR_EXC, CRS_SR_EXC_EXEC}) vexp[5:0] = e;
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic rd(crs_sr_sel_t s, logic [31:0] exp);
    i_sr_rd_sel = s;
    tick(2);
    chk("sr_rd", exp, o_sr_rd);
  endtask

  task automatic srw(crs_sr_sel_t s, logic [31:0] dt);
    i_sr_wr = {1'b1, s, dt};
    tick();
    i_sr_wr.we = 1'b0;
    tick();
  endtask

  // entry or return pulse; return restores current flags and isa
  task automatic evt(logic en, logic [5:0] n, logic [31:0] vec);
    i_exc = {en, ~en, n, vec, {flags, 3'h0, 1'b1, 24'h0}, 1'b1};
    tick();
    i_exc = '0;
    tick(2);
  endtask

  task automatic conclude();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    conclude();
  end

  initial begin
    v = rnd();
    main_stack_pointer = rnd();
    i_vec_sp = main_stack_pointer;
    i_vec_pc = v | 32'h1;
    tick(5);
    i_reset = 1'b0;
    i_vec_valid = 1'b1;
    tick(4);
    chk("ready", 32'h1, {31'h0, o_ready});
    chk("sp", main_stack_pointer, o_sp);
    chk("pc", {v[31:1], 1'b0}, o_pc);
    i_exec_req = 1'b1;
    tick(2);
    chk("fatal", 32'h0, {31'h0, o_fatal_fault});
    i_pc_data = v & ~32'h1;
    i_exchange = 1'b1;
    i_pc_we = 1'b1;
    tick();
    i_pc_we = 1'b0;
    tick(2);
    chk("fatal", 32'h1, {31'h0, o_fatal_fault});
    i_pc_data = v | 32'h1;
    i_pc_we = 1'b1;
    tick();
    i_pc_we = 1'b0;
    i_exec_req = 1'b0;
    tick(2);
    chk("fatal", 32'h0, {31'h0, o_fatal_fault});
    for (int r = 0; r < 15; r++) begin
      d = rnd();
      i_gpr_wr = {1'b1, r[3:0], d};
      tick();
      i_gpr_wr.we = 1'b0;
      i_gpr_rd_idx = r[3:0];
      tick(2);
      if (r == 13) main_stack_pointer = d;
      chk("gpr", d, r == 13 ? o_sp : o_gpr_rd);
    end
    d = rnd();
    flags = d[3:0];
    i_flag_wr = {1'b1, flags};
    tick();
    i_flag_wr.we = 1'b0;
    rd(CRS_SR_FLAG, {flags, 28'h0});
    foreach (vw[i]) begin
      d = rnd();
      srw(vw[i], d);
      if (vexp(vw[i], 4'hF, 6'h0) !== 32'h0) flags = d[31:28];
      rd(vw[i], vexp(vw[i], flags, CRS_EXC_THREAD));
    end
    i_cfg_prio_req = 1'b1;
    for (int m = 0; m < 2; m++) begin
      d = rnd();
      srw(CRS_SR_MASK, {d[31:1], m[0]});
      rd(CRS_SR_MASK, {31'h0, m[0]});
      chk("block", {31'h0, m[0]}, {31'h0, o_cfg_prio_block});
    end
    for (int c = 1; c >= 0; c--) begin
      i_cps_disable = c[0];
      i_cps_we = 1'b1;
      tick();
      i_cps_we = 1'b0;
      rd(CRS_SR_MASK, {31'h0, c[0]});
      chk("block", {31'h0, c[0]}, {31'h0, o_cfg_prio_block});
    end
    process_stack_pointer = rnd();
    srw(CRS_SR_PSP, process_stack_pointer);
    main_stack_pointer = rnd();
    srw(CRS_SR_MSP, main_stack_pointer);
    rd(CRS_SR_MSP, main_stack_pointer);
    rd(CRS_SR_PSP, process_stack_pointer);
    srw(CRS_SR_CONTROL, 32'hFFFFFFFF);
    rd(CRS_SR_CONTROL, 32'h2);
    chk("sp", process_stack_pointer, o_sp);
    foreach (ec[i]) begin
      v = rnd();
      evt(1'b1, ec[i], v | 32'h1);
      chk("handler", 32'h1, {31'h0, o_handler});
      chk("sp", main_stack_pointer, o_sp);
      chk("spsr", {flags, 4'h1, 24'h0}, o_stack_psr & 32'hF1000000);
      srw(CRS_SR_CONTROL, 32'h2);
      rd(CRS_SR_CONTROL, 32'h0);
      d = rnd();
      srw(CRS_SR_ALL, d);
      flags = d[31:28];
      rd(CRS_SR_EXC, {26'h0, ec[i]});
      evt(1'b0, 6'h0, 32'h0);
      chk("sp", process_stack_pointer, o_sp);
    end
    // abandoned transfer restarts at its first word
    i_multi_pc = rnd() & ~32'h1;
    i_multi_start = 1'b1;
    tick();
    i_multi_start = 1'b0;
    i_irq_take = 1'b1;
    tick();
    i_irq_take = 1'b0;
    chk("abandon", 32'h1, {31'h0, o_multi_abandon});
    evt(1'b1, CRS_EXC_IRQ_LO, rnd() | 32'h1);
    evt(1'b0, 6'h0, 32'h0);
    chk("pc", i_multi_pc, o_pc);
    // finished transfer is not abandoned by a later interrupt
    i_multi_start = 1'b1;
    tick();
    i_multi_start = 1'b0;
    i_multi_done = 1'b1;
    tick();
    i_multi_done = 1'b0;
    i_irq_take = 1'b1;
    tick();
    i_irq_take = 1'b0;
    chk("abandon", 32'h0, {31'h0, o_multi_abandon});
    conclude();
  end
endmodule

bind crs_core_regs crs_core_regs_sva u_sva (.i_clk, .i_reset, .i_vec_valid, .i_sr_rd_sel,
  .i_exec_req, .i_multi_start, .i_irq_take, .i_cfg_prio_req, .o_ready, .o_sr_rd, .o_handler,
  .o_fatal_fault, .o_multi_abandon, .o_cfg_prio_block);
